// File: src/flash_cpu_access.sv
// CPU-side flash access controller with address translation and wait states
`timescale 1ns/100ps
module flash_cpu_access (
   input  wire logic        i_sys_clk,
   input  wire logic        i_rst,
   // Wishbone register slave
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [3:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic      [31:0] o_wb_dat,
   output logic             o_wb_ack,
   // CPU flash access port
   input  wire logic        i_cpu_req,
   input  wire logic        i_cpu_we,
   input  wire logic        i_cpu_fetch,
   input  wire logic [1:0]  i_cpu_size,
   input  wire logic [23:0] i_cpu_addr,
   input  wire logic [31:0] i_cpu_wdata,
   output logic      [31:0] o_cpu_rdata,
   output logic             o_cpu_ready,
   output logic             o_cpu_error,
   // Flash macro port
   output logic             o_fl_cs,
   output logic             o_fl_we,
   output logic [20:0]      o_fl_macro_address,
   output logic [31:0]      o_fl_wdata,
   input  wire logic [63:0] i_fl_rdata
);

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WAIT = 3'b010,
      ST_DONE = 3'b100
   } state_t;

   state_t      state;
   logic [1:0]  mode;
   logic [10:0] rd_timing;
   logic [10:0] wr_timing;
   logic [3:0]  wait_cnt;
   logic        err_sticky;
   logic        cur_we;
   logic        cur_hi;
   logic        cur_half;

   // Translate a CPU address to a macro address; 24 bits, top three bits dropped by the caller
   function automatic logic [23:0] xlate(input logic [23:0] a);
      logic [23:0] blk;
      logic [23:0] base;
      logic [23:0] r;
      blk  = (a >= flash_access_pkg::SMALL_BASE) ? flash_access_pkg::SMALL_BLOCK
                                                 : flash_access_pkg::LARGE_BLOCK;
      base = a - (a % blk) + ((a % blk) >> 1) - ((a >> 1) % 24'h000004) + (a % 24'h000004);
      if (a >= flash_access_pkg::SMALL_BASE) begin
         r = base - flash_access_pkg::SMALL_SUB;
         if (a[2]) begin
            r = r + flash_access_pkg::SMALL_ODD;
         end
      end else begin
         r = base + flash_access_pkg::LARGE_ADD;
         if (a[2]) begin
            r = r + flash_access_pkg::LARGE_ODD;
         end
      end
      return r;
   endfunction

   function automatic logic in_flash(input logic [23:0] a);
      return (a >= flash_access_pkg::LARGE_BASE) && (a <= flash_access_pkg::SMALL_END);
   endfunction

   // Translated address of the pending request; a call result cannot be part-selected
   logic [23:0] xlated;
   assign xlated = xlate(i_cpu_addr);

   // Decide whether a request is legal in the current mode
   logic        cpu_bad;
   logic        secvec_hit;
   always_comb begin
      secvec_hit = (i_cpu_addr >= flash_access_pkg::SECVEC_LO) &&
                   (i_cpu_addr <= flash_access_pkg::SECVEC_HI);
      cpu_bad = !in_flash(i_cpu_addr);
      if (secvec_hit && i_cpu_we) begin
         cpu_bad = 1'b1;
      end
      unique case (mode)
         flash_access_pkg::MODE_64: begin
            if (i_cpu_we || i_cpu_size != 2'h2) begin
               cpu_bad = 1'b1;
            end
         end
         flash_access_pkg::MODE_32: begin
            if (i_cpu_size != 2'h2) begin
               cpu_bad = 1'b1;
            end
         end
         flash_access_pkg::MODE_16: begin
            if (i_cpu_fetch || i_cpu_size != 2'h1) begin
               cpu_bad = 1'b1;
            end
         end
         default: cpu_bad = 1'b1;
      endcase
   end

   // Wishbone slave: single-cycle ack, then drop
   logic wb_hit;
   assign wb_hit = i_wb_cyc && i_wb_stb && !o_wb_ack;
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_wb_ack  <= 1'b0;
         o_wb_dat  <= 32'h00000000;
         mode      <= flash_access_pkg::MODE_RESET;
         rd_timing <= flash_access_pkg::RD_TIMING_RST;
         wr_timing <= flash_access_pkg::WR_TIMING_RST;
      end else begin
         o_wb_ack <= wb_hit;
         o_wb_dat <= 32'h00000000;
         if (wb_hit && i_wb_we && i_wb_sel[0]) begin
            // Mode writes made mid-access are dropped, not deferred, to avoid mixed widths
            if (i_wb_adr == flash_access_pkg::REG_MODE && state == ST_IDLE &&
                i_wb_dat[1:0] != 2'h3) begin
               mode <= i_wb_dat[1:0];
            end
         end
         if (wb_hit && i_wb_we && i_wb_adr == flash_access_pkg::REG_RD_TIMING) begin
            if (i_wb_sel[0]) rd_timing[7:0] <= i_wb_dat[7:0];
            if (i_wb_sel[1]) rd_timing[10:8] <= i_wb_dat[10:8];
         end
         if (wb_hit && i_wb_we && i_wb_adr == flash_access_pkg::REG_WR_TIMING) begin
            if (i_wb_sel[0]) wr_timing[7:0] <= i_wb_dat[7:0];
            if (i_wb_sel[1]) wr_timing[10:8] <= i_wb_dat[10:8];
         end
         if (wb_hit && !i_wb_we) begin
            unique case (i_wb_adr)
               flash_access_pkg::REG_MODE:      o_wb_dat <= {30'h0, mode};
               flash_access_pkg::REG_RD_TIMING: o_wb_dat <= {21'h0, rd_timing};
               flash_access_pkg::REG_WR_TIMING: o_wb_dat <= {21'h0, wr_timing};
               flash_access_pkg::REG_STATUS:
                  o_wb_dat <= {29'h0, err_sticky, state != ST_IDLE, 1'b0};
               default:                         o_wb_dat <= 32'h00000000;
            endcase
         end
      end
   end

   // Sticky error flag; a new error wins over a clear in the same cycle
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         err_sticky <= 1'b0;
      end else if (state == ST_IDLE && i_cpu_req && cpu_bad) begin
         err_sticky <= 1'b1;
      end else if (wb_hit && i_wb_we && i_wb_adr == flash_access_pkg::REG_STATUS &&
                   i_wb_sel[0] && i_wb_dat[2]) begin
         err_sticky <= 1'b0;
      end
   end

   // Access sequencer: launch, count wait states, return data
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         state              <= ST_IDLE;
         wait_cnt           <= 4'h0;
         o_cpu_ready        <= 1'b0;
         o_cpu_error        <= 1'b0;
         o_cpu_rdata        <= 32'h00000000;
         o_fl_cs            <= 1'b0;
         o_fl_we            <= 1'b0;
         o_fl_macro_address <= 21'h000000;
         o_fl_wdata         <= 32'h00000000;
         cur_we             <= 1'b0;
         cur_hi             <= 1'b0;
         cur_half           <= 1'b0;
      end else begin
         o_cpu_ready <= 1'b0;
         o_cpu_error <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               if (i_cpu_req && cpu_bad) begin
                  o_cpu_ready <= 1'b1;
                  o_cpu_error <= 1'b1;
                  state       <= ST_DONE;
               end else if (i_cpu_req) begin
                  o_fl_cs            <= 1'b1;
                  o_fl_we            <= i_cpu_we;
                  o_fl_macro_address <= xlated[20:0];
                  // Double-word fetch ignores the low address bits
                  if (mode == flash_access_pkg::MODE_64) begin
                     o_fl_macro_address[2:0] <= 3'h0;
                  end
                  o_fl_wdata <= i_cpu_wdata;
                  cur_we     <= i_cpu_we;
                  cur_hi     <= i_cpu_addr[2];
                  cur_half   <= i_cpu_addr[1];
                  wait_cnt   <= i_cpu_we ? wr_timing[3:0] : rd_timing[3:0];
                  state      <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (wait_cnt > 4'h1) begin
                  wait_cnt <= wait_cnt - 4'h1;
               end else begin
                  o_fl_cs     <= 1'b0;
                  o_fl_we     <= 1'b0;
                  o_cpu_ready <= 1'b1;
                  state       <= ST_DONE;
                  if (!cur_we) begin
                     unique case (mode)
                        flash_access_pkg::MODE_64:
                           o_cpu_rdata <= cur_hi ? i_fl_rdata[63:32]
                                                 : i_fl_rdata[31:0];
                        flash_access_pkg::MODE_16:
                           o_cpu_rdata <= {16'h0000, cur_half ? i_fl_rdata[15:0]
                                                              : i_fl_rdata[31:16]};
                        default: o_cpu_rdata <= i_fl_rdata[31:0];
                     endcase
                  end
               end
            end
            ST_DONE: begin
               // Wait for the CPU to drop its request before taking another
               if (!i_cpu_req) begin
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Widest mode must never strobe a write into the array
   a_no_write_wide: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (mode == flash_access_pkg::MODE_64) |-> !o_fl_we)
      else $error("Array write in 64-bit mode");

   // Widest mode refuses a write before the macro is touched
   a_wide_write_err: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (state == ST_IDLE && i_cpu_req && i_cpu_we && mode == flash_access_pkg::MODE_64)
      |=> o_cpu_error && !o_fl_cs)
      else $error("Write accepted in 64-bit mode");

   // Widest mode hands out whole words only
   a_wide_word_only: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (state == ST_IDLE && i_cpu_req && mode == flash_access_pkg::MODE_64 &&
       i_cpu_size != 2'h2) |=> o_cpu_error)
      else $error("Non-word access in 64-bit mode");

   // Double-word fetches always start on an 8-byte boundary
   a_wide_align: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (o_fl_cs && mode == flash_access_pkg::MODE_64) |-> o_fl_macro_address[2:0] == 3'h0)
      else $error("Wide fetch not aligned");

   // Half-word mode cannot run code, so fetches come back as errors
   a_fetch_16_err: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (state == ST_IDLE && i_cpu_req && i_cpu_fetch && mode == flash_access_pkg::MODE_16)
      |=> o_cpu_error && o_cpu_ready)
      else $error("Fetch accepted in 16-bit mode");

   // Word mode refuses anything but a full word
   a_size_32: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (state == ST_IDLE && i_cpu_req && mode == flash_access_pkg::MODE_32 &&
       i_cpu_size != 2'h2) |=> o_cpu_error)
      else $error("Non-word access in 32-bit mode");

   // Half-word mode refuses anything but a half word
   a_size_16: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (state == ST_IDLE && i_cpu_req && mode == flash_access_pkg::MODE_16 &&
       i_cpu_size != 2'h1) |=> o_cpu_error)
      else $error("Non-half access in 16-bit mode");

   // Half-word reads return the chosen half in the low bits only
   a_half_upper_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (o_cpu_ready && !o_cpu_error && !cur_we && mode == flash_access_pkg::MODE_16)
      |-> o_cpu_rdata[31:16] == 16'h0000)
      else $error("Half-word read leaked upper bits");

   // Security vectors are read-only from the CPU side
   a_secvec_guard: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (state == ST_IDLE && i_cpu_req && i_cpu_we && secvec_hit) |=> !o_fl_cs)
      else $error("Security vector write reached array");

   // Spot mapping at the start of the odd small group
   a_xlate_small: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (state == ST_IDLE && i_cpu_req && !cpu_bad && mode != flash_access_pkg::MODE_64 &&
       i_cpu_addr == 24'h140004) |=> o_fl_macro_address == 21'h0F2000)
      else $error("Odd small sector mapping wrong");

   // Spot mapping at the start of the even large group
   a_xlate_large: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (state == ST_IDLE && i_cpu_req && !cpu_bad && mode != flash_access_pkg::MODE_64 &&
       i_cpu_addr == 24'h040000) |=> o_fl_macro_address == 21'h100000)
      else $error("Even large sector mapping wrong");

   // Address bit 2 alone picks the odd sector of each pair, in both regions
   a_small_pair: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (state == ST_IDLE && i_cpu_req && !cpu_bad &&
       i_cpu_addr >= flash_access_pkg::SMALL_BASE)
      |=> ((o_fl_macro_address & flash_access_pkg::SMALL_ODD[20:0]) != 21'h000000) ==
          $past(i_cpu_addr[2]))
      else $error("Small sector interleave wrong");
   a_large_pair: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (state == ST_IDLE && i_cpu_req && !cpu_bad &&
       i_cpu_addr < flash_access_pkg::SMALL_BASE)
      |=> ((o_fl_macro_address & flash_access_pkg::LARGE_ODD[20:0]) != 21'h000000) ==
          $past(i_cpu_addr[2]))
      else $error("Large sector interleave wrong");

   // Every access is stretched by the wait count and then answered
   a_ready_after_cs: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      $rose(o_fl_cs) |-> !o_cpu_ready [*1] ##[1:16] o_cpu_ready)
      else $error("Access not completed in wait window");
   a_cs_ends_ready: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      $fell(o_fl_cs) |-> o_cpu_ready && !o_cpu_error)
      else $error("Ready not tied to access end");

   // A stuck ready would complete one access twice
   a_ready_pulse: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      o_cpu_ready |=> !o_cpu_ready)
      else $error("Ready held longer than one cycle");
   a_error_has_ready: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      o_cpu_error |-> o_cpu_ready)
      else $error("Error without ready");
   a_cs_in_wait: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (state != ST_WAIT) |-> !o_fl_cs)
      else $error("Macro selected outside an access");

   // Select length counter; feeds only the bound check below
   logic [4:0] cs_len;
   always_ff @(posedge i_sys_clk) begin
      if (i_rst || !o_fl_cs) begin
         cs_len <= 5'h00;
      end else begin
         cs_len <= cs_len + 5'h01;
      end
   end

   // The 4-bit wait count caps an access at fifteen select cycles
   a_cs_bounded: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      o_fl_cs |-> cs_len < 5'h10)
      else $error("Macro select held too long");
endmodule // flash_cpu_access

// File: src/flash_access_pkg.sv
// Constants for the CPU-side flash access interface
// Overview of operation
// - 64-bit mode: word reads, double-word array fetch
// - 64-bit mode blocks all array writes
// - 32-bit mode: word reads, writes, fetches
// - 16-bit mode: half-word reads and writes
// - 16-bit mode refuses instruction fetches
// - Small region, bit2 clear: even 8 KB sectors
// - Small region, bit2 set: odd sectors, +2000h
// - Large region, bit2 clear: even 64 KB sectors
// - Large region, bit2 set: odd sectors, +10000h
// - Security vectors reserved at 14:8000h-14:800Fh
package flash_access_pkg;
   // Register byte offsets
   localparam logic [3:0]  REG_MODE       = 4'h0;
   localparam logic [3:0]  REG_RD_TIMING  = 4'h4;
   localparam logic [3:0]  REG_WR_TIMING  = 4'h8;
   localparam logic [3:0]  REG_STATUS     = 4'hC;
   // Access modes
   localparam logic [1:0]  MODE_64        = 2'h0;
   localparam logic [1:0]  MODE_32        = 2'h1;
   localparam logic [1:0]  MODE_16        = 2'h2;
   localparam logic [1:0]  MODE_RESET     = MODE_32;
   // Timing field layout: wait[3:0], eq[7:4], latch[8], detect[9], strobe_high[10]
   localparam int          TF_WAIT_LSB    = 0;
   localparam int          TF_EQ_LSB      = 4;
   localparam int          TF_LATCH_BIT   = 8;
   localparam int          TF_DETECT_BIT  = 9;
   localparam int          TF_STROBE_BIT  = 10;
   localparam logic [10:0] RD_TIMING_RST  = 11'h004;
   localparam logic [10:0] WR_TIMING_RST  = 11'h207;
   // Address map
   localparam logic [23:0] SMALL_BASE     = 24'h140000;
   localparam logic [23:0] SMALL_END      = 24'h14FFFF;
   localparam logic [23:0] LARGE_BASE     = 24'h040000;
   localparam logic [23:0] LARGE_END      = 24'h13FFFF;
   localparam logic [23:0] SMALL_BLOCK    = 24'h004000;
   localparam logic [23:0] SMALL_SUB      = 24'h050000;
   localparam logic [23:0] SMALL_ODD      = 24'h002000;
   localparam logic [23:0] LARGE_BLOCK    = 24'h020000;
   localparam logic [23:0] LARGE_ADD      = 24'h0C0000;
   localparam logic [23:0] LARGE_ODD      = 24'h010000;
   localparam logic [23:0] SECVEC_LO      = 24'h148000;
   localparam logic [23:0] SECVEC_HI      = 24'h14800F;
   localparam int          MADDR_W        = 21;
endpackage

// File: sim/flash_macro_model.sv
// Behavioural flash macro model facing the access controller
`timescale 1ns/100ps
module flash_macro_model (
   input  wire logic        i_sys_clk,
   input  wire logic        i_fl_cs,
   input  wire logic        i_fl_we,
   input  wire logic [20:0] i_fl_macro_address,
   input  wire logic [31:0] i_fl_wdata,
   output logic      [63:0] o_fl_rdata,
   output logic      [20:0] o_last_addr,
   output logic      [31:0] o_last_wdata,
   output logic      [7:0]  o_wr_count
);
   logic [31:0] word;
   logic [63:0] held;
   logic        prev_wr;
   initial begin
      held = 64'h0;
      prev_wr = 1'b0;
      o_wr_count = 8'h00;
   end
   // Data carries its own address; a deselected macro shows the inverse, never stale data
   assign word = {11'h2AA, i_fl_macro_address};
   assign o_fl_rdata = i_fl_cs ? {word ^ 32'h8000_0000, word} : ~held;
   // Writes counted once per strobe, so a long strobe is not a double write
   always @(posedge i_sys_clk) begin
      prev_wr <= i_fl_cs & i_fl_we;
      if (i_fl_cs) begin
         held <= o_fl_rdata;
         o_last_addr <= i_fl_macro_address;
      end
      if (i_fl_cs & i_fl_we & ~prev_wr) begin
         o_wr_count <= o_wr_count + 8'h01;
         o_last_wdata <= i_fl_wdata;
      end
   end
endmodule // flash_macro_model

// File: sim/flash_cpu_access_tb.sv
// Self-checking bench for the CPU-side flash access controller
`timescale 1ns/100ps
module flash_cpu_access_tb;
   logic        i_sys_clk, i_rst, i_wb_cyc, i_wb_stb, i_wb_we, i_cpu_req, i_cpu_we, i_cpu_fetch;
   logic        o_wb_ack, o_cpu_ready, o_cpu_error, o_fl_cs, o_fl_we, err;
   logic [1:0]  i_cpu_size;
   logic [3:0]  i_wb_adr;
   logic [23:0] i_cpu_addr;
   logic [31:0] i_wb_dat, o_wb_dat, i_cpu_wdata, o_cpu_rdata, o_fl_wdata, last_wdata, rd, w;
   logic [20:0] o_fl_macro_address, last_addr;
   logic [63:0] i_fl_rdata;
   logic [7:0]  wr_count, wc0;
   int          failures, n_compared, lat;
   logic [3:0]  offs[5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
   logic [31:0] rstv[5] = '{32'h1, 32'h4, 32'h207, 32'h0, 32'h0};
   logic [10:0] rdt[3] = '{11'h001, 11'h012, 11'h334};
   logic [23:0] ra[4] = '{24'h040000, 24'h0A1234, 24'h140000, 24'h14C00C};

   flash_cpu_access u_flash_cpu_access (.i_sys_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we,
      .i_wb_adr, .i_wb_sel(4'hF), .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_cpu_req, .i_cpu_we,
      .i_cpu_fetch, .i_cpu_size, .i_cpu_addr, .i_cpu_wdata, .o_cpu_rdata, .o_cpu_ready,
      .o_cpu_error, .o_fl_cs, .o_fl_we, .o_fl_macro_address, .o_fl_wdata, .i_fl_rdata);
   flash_macro_model u_flash_macro_model (.i_sys_clk, .i_fl_cs(o_fl_cs), .i_fl_we(o_fl_we),
      .i_fl_macro_address(o_fl_macro_address), .i_fl_wdata(o_fl_wdata), .o_fl_rdata(i_fl_rdata),
      .o_last_addr(last_addr), .o_last_wdata(last_wdata), .o_wr_count(wr_count));

   always #10 i_sys_clk = ~i_sys_clk;

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      if (failures == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // One classic cycle; ack is sampled at the edge, released only after it
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= we;
      i_wb_adr <= adr;
      i_wb_dat <= dat;
      // No cycle limit here; the watchdog ends a wait that never sees ack
      do @(posedge i_sys_clk); while (o_wb_ack !== 1'b1);
      rd = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      @(posedge i_sys_clk);
   endtask

   // CPU access; latency counts edges from drive to the edge that samples ready
   task automatic cpu(input logic we, fetch, input logic [1:0] sz, input logic [23:0] a,
                      input int exp_lat, input logic exp_err);
      lat = 0;
      i_cpu_req <= 1'b1;
      i_cpu_we <= we;
      i_cpu_fetch <= fetch;
      i_cpu_size <= sz;
      i_cpu_addr <= a;
      do begin
         @(posedge i_sys_clk);
         lat++;
      end while (o_cpu_ready !== 1'b1);
      rd = o_cpu_rdata;
      err = o_cpu_error;
      i_cpu_req <= 1'b0;
      @(posedge i_sys_clk);
      check(lat, exp_lat);
      check({31'h0, err}, {31'h0, exp_err});
   endtask

   // Expected macro address, straight from the translation formula
   function automatic logic [20:0] fa(input logic [23:0] a);
      logic [23:0] b, r;
      b = (a >= 24'h140000) ? 24'h004000 : 24'h020000;
      r = a - a % b + (a % b) / 2 - (a / 2) % 4 + a % 4;
      if (b == 24'h004000) r = r - 24'h050000 + (a[2] ? 24'h002000 : 24'h000000);
      else r = r + 24'h0C0000 + (a[2] ? 24'h010000 : 24'h000000);
      return r[20:0];
   endfunction

   // Hang guard, well above the roughly 124 cycles the sequence needs
   initial begin
      repeat (3000) @(posedge i_sys_clk);
      failures++;
      print_verdict();
   end

   initial begin
      {i_sys_clk, i_wb_cyc, i_wb_stb, i_wb_we, i_cpu_req, i_cpu_we, i_cpu_fetch} = 7'h00;
      {i_wb_adr, i_cpu_size, i_cpu_addr, i_wb_dat, i_cpu_wdata} = 94'h0;
      i_rst = 1'b1;
      failures = 0;
      n_compared = 0;
      repeat (2) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      @(posedge i_sys_clk);
      // Reset values, then an unmapped hole
      for (int i = 0; i < 5; i++) begin
         wb(1'b0, offs[i], 32'h0);
         check(rd, rstv[i]);
      end
      // Word reads in all four sector groups, one clock-range setting each
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, flash_access_pkg::REG_RD_TIMING, {21'h0, rdt[i % 3]});
         cpu(1'b0, 1'b0, 2'h2, ra[i], rdt[i % 3][3:0] + 2, 1'b0);
         check({11'h0, last_addr}, {11'h0, fa(ra[i])});
         check({10'h0, 1'b1, last_addr}, {11'h0, fa(ra[i])} + 32'h0020_0000);
         check({1'b0, rd[30:0]}, {1'b0, 10'h2AA, fa(ra[i])});
      end
      cpu(1'b0, 1'b1, 2'h2, 24'h040010, 3, 1'b0);
      cpu(1'b0, 1'b0, 2'h2, 24'h140004, 3, 1'b0);
      check({11'h0, last_addr}, {11'h0, fa(24'h140004)});
      cpu(1'b0, 1'b0, 2'h1, 24'h040000, 2, 1'b1);
      // Word write, then a refused write into the security vectors
      wb(1'b1, flash_access_pkg::REG_WR_TIMING, 32'h204);
      wc0 = wr_count;
      i_cpu_wdata <= 32'hC0DE_1234;
      cpu(1'b1, 1'b0, 2'h2, 24'h060008, 6, 1'b0);
      check(last_wdata, 32'hC0DE_1234);
      check({11'h0, last_addr}, {11'h0, fa(24'h060008)});
      cpu(1'b1, 1'b0, 2'h2, 24'h148004, 2, 1'b1);
      check(wr_count, wc0 + 8'h01);
      wb(1'b0, flash_access_pkg::REG_STATUS, 32'h0);
      check(rd, 32'h4);
      wb(1'b1, flash_access_pkg::REG_STATUS, 32'h4);
      wb(1'b0, flash_access_pkg::REG_STATUS, 32'h0);
      check(rd, 32'h0);
      // Widest mode: half chosen by bit 2, writes refused
      wb(1'b1, flash_access_pkg::REG_MODE, {30'h0, flash_access_pkg::MODE_64});
      w = {11'h2AA, fa(24'h140004)};
      cpu(1'b0, 1'b0, 2'h2, 24'h140004, 3, 1'b0);
      check(rd, w ^ 32'h8000_0000);
      check({29'h0, last_addr[2:0]}, 32'h0);
      w = {11'h2AA, fa(24'h140000)};
      cpu(1'b0, 1'b0, 2'h2, 24'h140000, 3, 1'b0);
      check(rd, w);
      cpu(1'b0, 1'b0, 2'h1, 24'h140000, 2, 1'b1);
      cpu(1'b1, 1'b0, 2'h2, 24'h040000, 2, 1'b1);
      check(wr_count, wc0 + 8'h01);
      // Half-word mode: halves by bit 1, fetch refused, half write taken
      wb(1'b1, flash_access_pkg::REG_MODE, {30'h0, flash_access_pkg::MODE_16});
      w = {11'h2AA, fa(24'h040002)};
      cpu(1'b0, 1'b0, 2'h1, 24'h040002, 3, 1'b0);
      check(rd & 32'hFFFF, w & 32'hFFFF);
      w = {11'h2AA, fa(24'h040000)};
      cpu(1'b0, 1'b0, 2'h1, 24'h040000, 3, 1'b0);
      check(rd & 32'hFFFF, w >> 16);
      cpu(1'b0, 1'b1, 2'h1, 24'h040000, 2, 1'b1);
      cpu(1'b0, 1'b0, 2'h2, 24'h040000, 2, 1'b1);
      cpu(1'b1, 1'b0, 2'h1, 24'h040002, 6, 1'b0);
      check(wr_count, wc0 + 8'h02);
      print_verdict();
   end
endmodule // flash_cpu_access_tb
